// [src/sas_defs.svh]
// Constants of the serial converter sequencer: timing counts, step numbers, widths
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

// Core clock and internal conversion clock rates
`define SAS_CORE_HZ        50000000
`define SAS_CK_HZ          400000
// Core cycles per internal clock tick
`define SAS_CK_DIV         (`SAS_CORE_HZ / `SAS_CK_HZ)

// Conversion cycle shape: 14 steps of 4 internal clocks
`define SAS_STEPS          14
`define SAS_PHASES         4
`define SAS_FIRST_BIT_STEP 5
`define SAS_LAST_BIT_STEP  12
`define SAS_FINAL_STEP     13

// Internal clocks to wait after chip select falls
`define SAS_CS_WAIT_TICKS  5

// Data widths and buffer depth
`define SAS_RESULT_W       8
`define SAS_ADDR_W         2
`define SAS_FIFO_DEPTH     8

// Reset values
`define SAS_RESULT_RST     8'h00
`define SAS_CHAN_RST       2'h0

`endif

// [src/sas_pkg.sv]
// Types and helper functions of the serial converter sequencer
`include "sas_defs.svh"

package sas_pkg;

  // Link side state, one-hot
  typedef enum logic [3:0] {
    SAS_IDLE = 4'b0001,
    SAS_WAIT = 4'b0010,
    SAS_XFER = 4'b0100,
    SAS_CONV = 4'b1000
  } sas_state_t;

  typedef logic [`SAS_RESULT_W-1:0] sas_result_t;
  typedef logic [`SAS_ADDR_W-1:0]   sas_chan_t;
  typedef logic [3:0]               sas_step_t;

  // Rising edge between a previous and a current sample
  function automatic logic sas_rise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction

  // Falling edge between a previous and a current sample
  function automatic logic sas_fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  // Result bit under trial in a given step, MSB first
  function automatic logic [2:0] sas_bit_of(input sas_step_t step);
    sas_step_t d;
    d = 4'(`SAS_LAST_BIT_STEP) - step;
    return d[2:0];
  endfunction

endpackage

// [src/sas_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sas_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule // sas_fifo

`default_nettype wire

// [src/sas_top.sv]
// Sequencer and serial link of an 8-bit successive-approximation converter
//
// Operation
// - Host shifts two address bits in, then strobes latch; latched value picks input.
// - Each 8-bit result leaves serially on an open-collector output pin.
// - All serial bit transfers are timed by the host's shift clock only.
// - Chip select rising starts a conversion cycle.
// - Final step loads result into output shift register, next cycle starts at once.
// - End-of-conversion goes low at final step of first conversion after rise.
// - Chip select low holds sequencer and end-of-conversion in reset.
// - Serial, clock and latch activity ignored while chip select is high.
// - Five internal clocks after select falls before data; host waits likewise.
// - A conversion is 14 steps of 4 internal clocks, 56 in total.
// - Input above reference gives an all-ones result.
// - New address accepted while the previous result is shifted out.
// - Address bit0/bit1: LL input 0, HL input 1, LH input 2, HH input 3.
// - Chip select ending the exchange releases the output pin.
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.svh"

module sas_top (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // Serial link pins
  input  wire logic                  cs_n,
  input  wire logic                  shift_clk,
  input  wire logic                  serial_in,
  input  wire logic                  channel_latch_strobe,
  output logic                       serial_out,
  output logic                       serial_out_oe,
  output logic                       eoc_n,
  // Analog front end
  output logic                       analog_input_0,
  output logic                       analog_input_1,
  output logic                       analog_input_2,
  output logic                       analog_input_3,
  output sas_pkg::sas_result_t       dac_code,
  input  wire logic                  comparator_high,
  input  wire logic                  over_reference,
  // Result stream
  output logic                       result_valid,
  input  wire logic                  result_ready,
  output sas_pkg::sas_result_t       result_data,
  output logic                       capture_ready
);
  import sas_pkg::*;

  localparam logic [7:0] CK_DIV   = 8'(`SAS_CK_DIV);
  localparam sas_step_t  FINAL    = 4'(`SAS_FINAL_STEP);
  localparam sas_step_t  FIRST_B  = 4'(`SAS_FIRST_BIT_STEP);
  localparam sas_step_t  LAST_B   = 4'(`SAS_LAST_BIT_STEP);
  localparam logic [1:0] LAST_PH  = 2'(`SAS_PHASES - 1);
  localparam logic [2:0] WAIT_TK  = 3'(`SAS_CS_WAIT_TICKS);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic [1:0] si_sync;
  logic [1:0] stb_sync;
  logic [1:0] cmp_sync;
  logic [1:0] ovr_sync;
  logic       cs_prev;
  logic       sck_prev;
  logic       stb_prev;

  // Two flops on every pin input; resets idle chip select high
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cs_sync  <= 2'h3;
      sck_sync <= 2'h3;
      si_sync  <= 2'h0;
      stb_sync <= 2'h0;
      cmp_sync <= 2'h0;
      ovr_sync <= 2'h0;
    end else begin
      cs_sync  <= {cs_sync[0], cs_n};
      sck_sync <= {sck_sync[0], shift_clk};
      si_sync  <= {si_sync[0], serial_in};
      stb_sync <= {stb_sync[0], channel_latch_strobe};
      cmp_sync <= {cmp_sync[0], comparator_high};
      ovr_sync <= {ovr_sync[0], over_reference};
    end
  end

  // Previous samples for edge finding
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cs_prev  <= 1'b1;
      sck_prev <= 1'b1;
      stb_prev <= 1'b0;
    end else begin
      cs_prev  <= cs_sync[1];
      sck_prev <= sck_sync[1];
      stb_prev <= stb_sync[1];
    end
  end

  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic stb_rise;

  assign cs_rise  = sas_rise(cs_prev, cs_sync[1]);
  assign cs_fall  = sas_fall(cs_prev, cs_sync[1]);
  assign sck_rise = sas_rise(sck_prev, sck_sync[1]);
  assign sck_fall = sas_fall(sck_prev, sck_sync[1]);
  assign stb_rise = sas_rise(stb_prev, stb_sync[1]);

  //////////////////////////////////////////////////////////////////////////////
  // Internal clock divider

  logic [7:0] div_cnt;
  logic       tick;

  assign tick = (div_cnt == CK_DIV - 8'h01);

  // Restarted on each chip select edge so timing counts from the edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      div_cnt <= 8'h00;
    end else if (cs_rise || cs_fall || tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link state machine

  sas_state_t state;
  sas_state_t next_state;
  logic [2:0] wait_cnt;

  // Next state from chip select and the wait count
  always_comb begin
    next_state = state;
    case (state)
      SAS_IDLE: begin
        if (cs_rise) next_state = SAS_CONV;
        else if (cs_fall) next_state = SAS_WAIT;
      end
      SAS_CONV: begin
        if (cs_fall) next_state = SAS_WAIT;
      end
      SAS_WAIT: begin
        if (cs_rise) next_state = SAS_CONV;
        else if (tick && wait_cnt == WAIT_TK - 3'h1) next_state = SAS_XFER;
      end
      SAS_XFER: begin
        if (cs_rise) next_state = SAS_CONV;
      end
      default: next_state = SAS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= SAS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Count internal clocks after chip select falls
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wait_cnt <= 3'h0;
    end else if (state != SAS_WAIT || cs_rise) begin
      wait_cnt <= 3'h0;
    end else if (tick) begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  sas_step_t  step;
  logic [1:0] phase;
  logic       running;
  logic       step_end;
  logic       conv_done;
  logic       first_done;

  assign running   = (state == SAS_CONV) && !cs_fall;
  assign step_end  = running && tick && (phase == LAST_PH);
  assign conv_done = step_end && (step == FINAL);

  // 14 steps of 4 internal clocks; held at zero while select is low
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      step  <= 4'h0;
      phase <= 2'h0;
    end else if (!running) begin
      step  <= 4'h0;
      phase <= 2'h0;
    end else if (tick) begin
      phase <= phase + 2'h1;
      if (phase == LAST_PH) begin
        step <= (step == FINAL) ? 4'h0 : step + 4'h1;
      end
    end
  end

  // Trial code: set bit at step start, keep or drop at step end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dac_code <= `SAS_RESULT_RST;
    end else if (!running) begin
      dac_code <= `SAS_RESULT_RST;
    end else if (tick && step >= FIRST_B && step <= LAST_B) begin
      if (phase == 2'h0) begin
        dac_code[sas_bit_of(step)] <= 1'b1;
      end else if (phase == LAST_PH) begin
        dac_code[sas_bit_of(step)] <= cmp_sync[1];
      end
    end else if (conv_done) begin
      dac_code <= `SAS_RESULT_RST;
    end
  end

  sas_result_t conv_result;

  assign conv_result = ovr_sync[1] ? {`SAS_RESULT_W{1'b1}} : dac_code;

  // End of conversion: low after first cycle, reset while select low
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      first_done <= 1'b0;
    end else if (!cs_sync[1]) begin
      first_done <= 1'b0;
    end else if (conv_done) begin
      first_done <= 1'b1;
    end
  end

  assign eoc_n = !first_done;

  //////////////////////////////////////////////////////////////////////////////
  // Result buffer toward the on-chip consumer

  sas_fifo #(
    .WIDTH (`SAS_RESULT_W),
    .DEPTH (`SAS_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (conv_done),
    .in_ready  (capture_ready),
    .in_data   (conv_result),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Serial exchange

  sas_result_t out_shift;
  sas_chan_t   addr_shift;
  sas_chan_t   channel;
  logic        xfer;

  assign xfer = (state == SAS_XFER) && cs_sync[1] == 1'b0;

  // Output shift register: newest result, then MSB first per falling edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_shift <= `SAS_RESULT_RST;
    end else if (conv_done) begin
      out_shift <= conv_result;
    end else if (xfer && sck_fall) begin
      out_shift <= {out_shift[`SAS_RESULT_W-2:0], 1'b1};
    end
  end

  // Address shift register, bit0 first on rising edges
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      addr_shift <= `SAS_CHAN_RST;
    end else if (xfer && sck_rise) begin
      addr_shift <= {si_sync[1], addr_shift[1]};
    end
  end

  // Channel latch on strobe rise, only inside an exchange
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      channel <= `SAS_CHAN_RST;
    end else if (xfer && stb_rise) begin
      channel <= addr_shift;
    end
  end

  // Multiplexer select from latched channel
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      analog_input_0 <= 1'b1;
      analog_input_1 <= 1'b0;
      analog_input_2 <= 1'b0;
      analog_input_3 <= 1'b0;
    end else begin
      analog_input_0 <= (channel == 2'h0);
      analog_input_1 <= (channel == 2'h1);
      analog_input_2 <= (channel == 2'h2);
      analog_input_3 <= (channel == 2'h3);
    end
  end

  // Open-collector output: only ever pulls low, released outside exchange
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      serial_out_oe <= 1'b0;
    end else if (xfer && !cs_rise) begin
      serial_out_oe <= !out_shift[`SAS_RESULT_W-1];
    end else begin
      serial_out_oe <= 1'b0;
    end
  end

  assign serial_out = 1'b0;

endmodule // sas_top

`default_nettype wire

// [verif/sas_monitor.sv]
// Port checker of the serial converter sequencer
`timescale 1ns/1ps
`default_nettype none

module sas_monitor (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 reset,
  // Link
  input wire logic                 cs_n,
  input wire logic                 serial_out_oe,
  input wire logic                 eoc_n,
  // Front end
  input wire logic                 analog_input_0,
  input wire logic                 analog_input_1,
  input wire logic                 analog_input_2,
  input wire logic                 analog_input_3,
  input wire logic                 over_reference,
  // Result stream
  input wire logic                 result_valid,
  input wire logic                 result_ready,
  input wire sas_pkg::sas_result_t result_data
);
  import sas_pkg::*;
  logic [3:0]  sel;
  logic [15:0] high_run;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  assign sel = {analog_input_3, analog_input_2, analog_input_1, analog_input_0};

  // Cycles seen with select high
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      high_run <= 16'h0000;
    end else if (!cs_n) begin
      high_run <= 16'h0000;
    end else if (high_run != 16'hffff) begin
      high_run <= high_run + 16'h0001;
    end
  end

  ////////////////////////////////////////
  // Multiplexer and select
  a_chan_one_hot: assert property ($onehot(sel))
    else $error("channel select not one-hot");
  a_chan_frozen_high: assert property (cs_n [*6] |-> $stable(sel))
    else $error("channel changed while deselected");
  // End of conversion
  a_eoc_conv_time: assert property ($fell(eoc_n) |->
    (high_run >= 16'h1b58) && (high_run <= 16'h1b64))
    else $error("first conversion length wrong");
  a_eoc_stays_low: assert property ((!eoc_n && cs_n) |=> !eoc_n)
    else $error("end flag left low state");
  a_eoc_cleared_low: assert property (!cs_n [*6] |-> eoc_n)
    else $error("end flag not cleared");
  a_eoc_rise_cause: assert property ($rose(eoc_n) |-> !$past(cs_n, 2))
    else $error("end flag cleared without select");
  // Output pin
  a_pin_free_high: assert property (cs_n [*6] |-> !serial_out_oe)
    else $error("pin driven while deselected");
  a_pin_quiet_wait: assert property ($fell(cs_n) |=> !serial_out_oe [*8])
    else $error("pin driven during wait");
  // Result stream
  a_over_all_ones: assert property ($rose(result_valid) && over_reference &&
    $past(over_reference, 8) |-> result_data == 8'hff)
    else $error("over reference result not all ones");
  a_fifo_head_hold: assert property ((result_valid && !result_ready) |=>
    result_valid && $stable(result_data))
    else $error("stalled head changed");
endmodule // sas_monitor

bind sas_top sas_monitor mon (.core_clk, .reset, .cs_n, .serial_out_oe, .eoc_n,
  .analog_input_0, .analog_input_1, .analog_input_2, .analog_input_3, .over_reference,
  .result_valid, .result_ready, .result_data);
`default_nettype wire

// [verif/sas_host_model.sv]
// Host side of the serial link: select, shift clock, address, latch
`timescale 1ns/1ps
`default_nettype none

module sas_host_model (
  // Clock
  input  wire logic core_clk,
  // Result pin
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  // Host drives
  output logic      cs_n,
  output logic      shift_clk,
  output logic      serial_in,
  output logic      channel_latch_strobe
);
  import sas_pkg::*;
  logic pin;

  // Open-collector pin with pull-up
  assign pin = serial_out_oe ? serial_out : 1'b1;

  // Idle link, shift clock parked high
  initial begin
    cs_n = 1'b1;
    shift_clk = 1'b1;
    serial_in = 1'b0;
    channel_latch_strobe = 1'b0;
  end

  ////////////////////////////////////////
  // Wait falling edges
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Read a result, load a channel, end deselected
  task automatic frame(input sas_chan_t ch, output sas_result_t got);
    cs_n = 1'b0;
    hold(640);
    for (int i = 7; i >= 0; i--) begin
      got[i] = pin;
      shift_clk = 1'b0;
      serial_in = (i == 1) ? ch[0] : ((i == 0) ? ch[1] : ~serial_in);
      hold(4);
      shift_clk = 1'b1;
      hold(4);
    end
    hold(6);
    channel_latch_strobe = 1'b1;
    hold(10);
    channel_latch_strobe = 1'b0;
    hold(6);
    cs_n = 1'b1;
    hold(10);
  endtask

  // Shift and latch while deselected
  task automatic noise(input sas_chan_t ch);
    for (int i = 0; i < 2; i++) begin
      shift_clk = 1'b0;
      serial_in = ch[i];
      hold(4);
      shift_clk = 1'b1;
      hold(4);
    end
    channel_latch_strobe = 1'b1;
    hold(10);
    channel_latch_strobe = 1'b0;
  endtask
endmodule // sas_host_model
`default_nettype wire

// [verif/sas_top_tb.sv]
// Self-checking bench of the serial converter sequencer
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end

module sas_top_tb;
  import sas_pkg::*;
  logic        core_clk, reset, cs_n, shift_clk, serial_in, channel_latch_strobe;
  logic        serial_out, serial_out_oe, eoc_n, comparator_high, over_reference;
  logic        analog_input_0, analog_input_1, analog_input_2, analog_input_3;
  logic        result_valid, result_ready, capture_ready;
  sas_result_t dac_code, result_data, vin;
  logic [3:0]  sel;
  int          bad_count = 0;
  int          n_checks = 0;

  assign sel = {analog_input_3, analog_input_2, analog_input_1, analog_input_0};

  // Core clock, 20 ns
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Comparator: input at or above trial code
  always @(negedge core_clk) comparator_high <= (vin >= dac_code);

  // Design and host
  sas_top dut (.core_clk, .reset, .cs_n, .shift_clk, .serial_in, .channel_latch_strobe,
    .serial_out, .serial_out_oe, .eoc_n, .analog_input_0, .analog_input_1, .analog_input_2,
    .analog_input_3, .dac_code, .comparator_high, .over_reference, .result_valid,
    .result_ready, .result_data, .capture_ready);
  sas_host_model host (.core_clk, .serial_out, .serial_out_oe, .cs_n, .shift_clk,
    .serial_in, .channel_latch_strobe);

  ////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Bounded wait for end flag (0) or full buffer (1)
  task automatic wait_low(input int which, input int lim);
    int n;
    n = 0;
    while (((which == 0) ? eoc_n : capture_ready) !== 1'b0) begin
      @(negedge core_clk);
      n++;
      if (n > lim) begin
        bad_count++;
        $display("ERROR wait %0d ran out", which);
        close_out();
      end
    end
  endtask

  ////////////////////////////////////////
  // Values after reset
  task automatic t_reset();
    `CHK("eoc_n", 1'b1, eoc_n);
    `CHK("pin enable", 1'b0, serial_out_oe);
    `CHK("channel", 4'h1, sel);
    `CHK("fifo valid", 1'b0, result_valid);
  endtask

  // Every channel code
  task automatic t_channels();
    sas_result_t got;
    for (int k = 1; k <= 4; k++) begin
      host.frame(2'(k % 4), got);
      `CHK("channel", 4'h1 << (k % 4), sel);
      `CHK("pin enable", 1'b0, serial_out_oe);
    end
  endtask

  // Activity while deselected
  task automatic t_noise();
    host.noise(2'h3);
    `CHK("channel", 4'h1, sel);
  endtask

  // One conversion read back and popped
  task automatic t_convert(input sas_result_t v, input logic ovr, input sas_result_t exp);
    sas_result_t got;
    vin = v;
    over_reference = ovr;
    host.frame(2'h2, got);
    wait_low(0, 7200);
    host.frame(2'h1, got);
    `CHK("result", exp, got);
    `CHK("eoc_n", 1'b1, eoc_n);
    `CHK("channel", 4'h2, sel);
    `CHK("fifo data", exp, result_data);
    result_ready = 1'b1;
    @(negedge core_clk);
    result_ready = 1'b0;
    @(negedge core_clk);
    `CHK("fifo empty", 1'b0, result_valid);
  endtask

  // Fill while stalled, newest result, drain
  task automatic t_fill();
    sas_result_t got;
    vin = 8'h33;
    over_reference = 1'b0;
    host.frame(2'h3, got);
    wait_low(1, 60000);
    vin = 8'hc4;
    repeat (7100) @(negedge core_clk);
    host.frame(2'h3, got);
    `CHK("newest result", 8'hc4, got);
    result_ready = 1'b1;
    for (int k = 0; k < 8; k++) begin
      `CHK("drain data", 8'h33, result_data);
      @(negedge core_clk);
    end
    result_ready = 1'b0;
    `CHK("drained", 1'b0, result_valid);
    `CHK("room", 1'b1, capture_ready);
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    over_reference = 1'b0;
    result_ready = 1'b0;
    vin = 8'h00;
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_channels();
    t_noise();
    t_convert(8'h5a, 1'b0, 8'h5a);
    t_convert(8'h00, 1'b1, 8'hff);
    t_fill();
    close_out();
  end
endmodule // sas_top_tb
`default_nettype wire
